//--- hw/hss_pkg.sv
package hss_pkg;
  localparam int CLK_PERIOD_NS = 50;
  // Master serial clock half period
  localparam int SCK_HALF_NS = 200;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_W = 3;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int NUM_CS = 8;
  localparam int EDGES_PER_BYTE = 16;
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  localparam logic [7:0] CSN_IDLE = 8'hFF;
  localparam logic ADR_DATA = 1'h0;
  localparam logic ADR_STAT = 1'h1;
  localparam int SB_FAULT = 0;
  localparam int SB_RX_FULL = 1;
  localparam int SB_RX_OVR = 2;
  localparam int SB_TX_FULL = 3;
  localparam int SB_BUSY = 4;
  typedef struct packed {
    logic master;
    logic cpol;
    logic cpha;
    logic lsb_first;
    logic wake_en;
    logic irq_en;
    logic [2:0] cs_sel;
  } hss_cfg_t;
  typedef struct packed {
    logic clk;
    logic miso;
    logic mosi;
    logic scsn;
    logic flash_n;
  } hss_pins_t;
  // Deselected, clock low
  localparam hss_pins_t PINS_RST = 5'h03;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_DONE = 2'h3
  } hss_state_t;
endpackage : hss_pkg

//--- hw/hss_core.sv
// How it works
// - Config bit selects master or slave operation.
// - As master the core starts and clocks every transfer itself.
// - Serial clock driven as master, received as slave.
// - MISO is input as master, driven as selected slave.
// - MOSI is driven as master, input as slave.
// - Master drives one of eight active-low chip selects.
// - Mode fault sets a sticky flag and can raise the interrupt.
// - Clock polarity and phase are both programmable.
// - Bytes shift LSB first or MSB first as configured.
// - Data and status reached over a byte-wide WISHBONE slave.
// - Standby and wake outputs act only when wake is enabled.
`timescale 1ns/1ns
`default_nettype none
module hss_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule : hss_fifo

module hss_core (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire hss_pkg::hss_cfg_t cfg,
  input wire logic stdby_req,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic wb_adr,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack,
  input wire logic spi_clk_i,
  output logic spi_clk_o,
  output logic spi_clk_oe,
  input wire logic spi_miso_i,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic spi_mosi_i,
  output logic spi_mosi_o,
  output logic spi_mosi_oe,
  output logic [7:0] spi_csn,
  input wire logic spi_scsn,
  input wire logic flash_select_n,
  output logic spi_irq,
  output logic busy,
  output logic cfg_stdby,
  output logic cfg_wake
);
  import hss_pkg::*;

  function automatic logic bit_of(input logic [7:0] v, input logic lsb);
    bit_of = lsb ? v[0] : v[7];
  endfunction : bit_of

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  hss_pins_t pin_s1;
  hss_pins_t pin_s2;
  hss_state_t state;
  logic sclk_d, sclk_q, out_q, in_bit, cs_on, fault, rx_full, rx_ovr, sel_d;
  logic [HALF_W-1:0] half_cnt;
  logic [3:0] edge_cnt;
  logic [2:0] cs_idx;
  logic [7:0] sh, rx_data, status;
  logic tx_valid, tx_in_ready;
  logic [7:0] tx_data;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= PINS_RST;
      pin_s2 <= PINS_RST;
      sclk_d <= 1'b0;
    end else begin
      pin_s1 <= '{spi_clk_i, spi_miso_i, spi_mosi_i, spi_scsn, flash_select_n};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2.clk;
    end
  end

  wire slave_sel = ~cfg.master & ~pin_s2.scsn & pin_s2.flash_n;
  wire master_clash = cfg.master & ~pin_s2.scsn;
  wire din = cfg.master ? pin_s2.miso : pin_s2.mosi;
  wire half_wrap = half_cnt == HALF_W'(SCK_HALF_CYC - 1);
  wire in_shift = state == ST_SHIFT;
  wire in_idle = state == ST_IDLE;
  wire master_edge = cfg.master & in_shift & half_wrap;
  wire slave_edge = ~cfg.master & in_shift & (pin_s2.clk ^ sclk_d);
  wire edge_ev = master_edge | slave_edge;
  // Edges alternate lead and trail, so one count serves both polarities
  wire lead_ev = edge_ev & ~edge_cnt[0];
  wire trail_ev = edge_ev & edge_cnt[0];
  wire samp = cfg.cpha ? din : in_bit;
  wire [7:0] next_sh = shift_in(sh, samp, cfg.lsb_first);
  wire byte_done = trail_ev & (edge_cnt == 4'(EDGES_PER_BYTE - 1));
  wire start_m = cfg.master & in_idle & tx_valid & ~fault & ~master_clash;
  wire start_s = ~cfg.master & in_idle & slave_sel;
  wire load = start_m | start_s;
  // Slave with nothing queued answers all ones
  wire [7:0] tx_byte = tx_valid ? tx_data : IDLE_FILL;
  wire slave_drop = ~cfg.master & in_shift & ~slave_sel;
  wire abort = master_clash | slave_drop;
  wire fault_set = master_clash | (slave_drop & edge_cnt != 4'h0);

  wire wb_req = wb_cyc & wb_stb & ~wb_ack;
  wire wr_data = wb_we & wb_adr == ADR_DATA;
  // A full transmit queue holds the write off until a byte leaves
  wire accept = wb_req & (~wr_data | tx_in_ready);
  wire rd_clear = accept & ~wb_we & wb_adr == ADR_DATA;
  wire wr_stat = accept & wb_we & wb_adr == ADR_STAT;

  hss_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .in_valid(accept & wr_data),
    .in_ready(tx_in_ready),
    .in_data(wb_dat_i),
    .out_valid(tx_valid),
    .out_ready(load),
    .out_data(tx_data)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else if (abort) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (load) state <= ST_SHIFT;
        ST_SHIFT: if (byte_done) state <= cfg.master ? ST_DONE : ST_IDLE;
        ST_DONE: if (half_wrap) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt <= '0;
      edge_cnt <= '0;
    end else begin
      half_cnt <= (in_idle | half_wrap) ? '0 : half_cnt + HALF_W'(1);
      edge_cnt <= in_idle ? 4'h0 : edge_cnt + 4'(edge_ev);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_on <= 1'b0;
      cs_idx <= '0;
    end else begin
      if (in_idle) sclk_q <= cfg.cpol;
      else if (master_edge) sclk_q <= ~sclk_q;
      if (start_m) cs_idx <= cfg.cs_sel;
      // Select stays low for a half period after the last edge
      cs_on <= ~master_clash & (start_m | (cs_on & ~(state == ST_DONE & half_wrap)));
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh <= '0;
      out_q <= 1'b0;
      in_bit <= 1'b0;
    end else if (load) begin
      sh <= tx_byte;
      out_q <= bit_of(tx_byte, cfg.lsb_first);
    end else if (lead_ev) begin
      if (!cfg.cpha) in_bit <= din;
      else out_q <= bit_of(sh, cfg.lsb_first);
    end else if (trail_ev) begin
      sh <= next_sh;
      if (!cfg.cpha) out_q <= bit_of(next_sh, cfg.lsb_first);
    end
  end

  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault <= 1'b0;
      rx_full <= 1'b0;
      rx_ovr <= 1'b0;
      rx_data <= '0;
    end else begin
      fault <= fault_set | (fault & ~(wr_stat & wb_dat_i[SB_FAULT]));
      rx_full <= byte_done | (rx_full & ~rd_clear);
      rx_ovr <= (byte_done & rx_full & ~rd_clear) | (rx_ovr & ~(wr_stat & wb_dat_i[SB_RX_OVR]));
      if (byte_done) rx_data <= next_sh;
    end
  end

  always_comb begin
    status = 8'h00;
    status[SB_FAULT] = fault;
    status[SB_RX_FULL] = rx_full;
    status[SB_RX_OVR] = rx_ovr;
    status[SB_TX_FULL] = ~tx_in_ready;
    status[SB_BUSY] = busy;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack <= accept;
      if (accept & ~wb_we) wb_dat_o <= wb_adr == ADR_STAT ? status : rx_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_d <= 1'b0;
      cfg_stdby <= 1'b0;
      cfg_wake <= 1'b0;
    end else begin
      sel_d <= slave_sel;
      cfg_stdby <= cfg.wake_en & stdby_req;
      cfg_wake <= cfg.wake_en & slave_sel & ~sel_d;
    end
  end

  assign busy = ~in_idle;
  assign spi_irq = fault & cfg.irq_en;
  assign spi_clk_o = sclk_q;
  // Pins are released on a fault so two masters never fight
  assign spi_clk_oe = cfg.master & ~fault;
  assign spi_mosi_o = out_q;
  assign spi_mosi_oe = cfg.master & ~fault;
  assign spi_miso_o = out_q;
  assign spi_miso_oe = slave_sel;
  assign spi_csn = cs_on ? ~(8'h01 << cs_idx) : CSN_IDLE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    start_m & ~abort;
  endsequence
  sequence s_selected;
    ##1 spi_csn != CSN_IDLE;
  endsequence
  property p_master_start;
    s_start |-> s_selected;
  endproperty
  a_master_start: assert property (p_master_start) else $error("no select after start");
  property p_cs_onehot;
    $onehot0(~spi_csn);
  endproperty
  a_cs_onehot: assert property (p_cs_onehot) else $error("more than one select");
  property p_clk_dir;
    spi_clk_oe |-> cfg.master;
  endproperty
  a_clk_dir: assert property (p_clk_dir) else $error("slave drives clock");
  property p_miso_dir;
    spi_miso_oe |-> !cfg.master && !spi_mosi_oe;
  endproperty
  a_miso_dir: assert property (p_miso_dir) else $error("bad miso drive");
  property p_mosi_dir;
    !cfg.master |-> !spi_mosi_oe;
  endproperty
  a_mosi_dir: assert property (p_mosi_dir) else $error("slave drives mosi");
  property p_clk_idle;
    cfg.master && in_idle && $past(in_idle) |-> spi_clk_o == $past(cfg.cpol);
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("idle clock level");
  property p_fault_irq;
    master_clash && cfg.irq_en |=> spi_irq;
  endproperty
  a_fault_irq: assert property (p_fault_irq) else $error("fault not signalled");
  property p_clash_release;
    master_clash |=> !spi_clk_oe && !spi_mosi_oe && spi_csn == CSN_IDLE && in_idle;
  endproperty
  a_clash_release: assert property (p_clash_release) else $error("pins held in fault");
  property p_wake_gate;
    !$past(cfg.wake_en) |-> !cfg_stdby && !cfg_wake;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake output not gated");
  property p_ack_pulse;
    wb_req && !(wb_we && wb_adr == ADR_DATA) |=> wb_ack ##1 !wb_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");
  property p_rx_store;
    byte_done |=> rx_full && rx_data == $past(next_sh);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("byte not stored");
  property p_lsb_first;
    load && cfg.lsb_first |=> out_q == $past(tx_byte[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("wrong first bit");
endmodule : hss_core
`default_nettype wire

//--- dv/hss_spi_peer.sv
`timescale 1ns/1ns
`default_nettype none
module hss_spi_peer (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  int n;
  wire s = sclk ^ cpol ^ cpha;
  // Released line shows the inverse so a stale bit never passes
  assign miso = cs_n ? ~sh[7] : sh[7];
  always @(negedge cs_n) begin
    sh = tx;
    n = 0;
  end
  always @(posedge s) if (!cs_n) begin
    rx = {rx[6:0], mosi};
    n = n + 1;
  end
  // No shift before the first sample, so phase 1 keeps its first bit
  always @(negedge s) if (!cs_n && n > 0) sh = {sh[6:0], 1'b0};
endmodule : hss_spi_peer
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hss_pkg::*;
  logic core_clk, rst_b, stdby_req, wb_cyc, wb_stb, wb_we, wb_adr, wb_ack, tsclk, tmosi, tscsn;
  logic fsn, clk_o, clk_oe, miso_o, miso_oe, mosi_o, mosi_oe, pmiso, irq, busy, stdby, wake, ok;
  logic [7:0] wb_dat_i, wb_dat_o, spi_csn, ptx, prx, d, got;
  hss_cfg_t cfg;
  int bad_count, num_checks, i, k, n;
  wire logic sclk_w = clk_oe ? clk_o : tsclk;
  wire logic mosi_w = mosi_oe ? mosi_o : tmosi;
  wire logic miso_w = miso_oe ? miso_o : pmiso;
  hss_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .stdby_req(stdby_req),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .spi_clk_i(sclk_w), .spi_clk_o(clk_o),
    .spi_clk_oe(clk_oe), .spi_miso_i(miso_w), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
    .spi_mosi_i(mosi_w), .spi_mosi_o(mosi_o), .spi_mosi_oe(mosi_oe), .spi_csn(spi_csn),
    .spi_scsn(tscsn), .flash_select_n(fsn), .spi_irq(irq), .busy(busy), .cfg_stdby(stdby),
    .cfg_wake(wake));
  hss_spi_peer peer_u (.sclk(sclk_w), .cs_n(spi_csn[3]), .mosi(mosi_w), .cpol(cfg.cpol),
    .cpha(cfg.cpha), .tx(ptx), .miso(pmiso), .rx(prx));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    #400000;
    bad_count++;
    test_done();
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #5;
  endtask : tick
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int j = 0; j < 8; j++) rev[j] = v[7 - j];
  endfunction : rev
  // Holds the cycle until ack; gives up after a bound so a refusal shows as ok low
  task automatic wb(input logic we, input logic adr, input logic [7:0] di);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i} = {2'b11, we, adr, di};
    ok = 0;
    for (int j = 0; j < 40 && !ok; j++) begin
      @(posedge core_clk);
      #5;
      ok = (wb_ack === 1'b1);
    end
    if (ok) d = wb_dat_o;
    // Request stands until the edge that samples ack high
    tick(1);
    {wb_cyc, wb_stb} = 2'b00;
    tick(1);
  endtask : wb
  task automatic t_master(input logic [2:0] m);
    cfg = {1'b1, m, 2'b01, 3'h3};
    ptx = 8'hC5 ^ {5'h00, m};
    tick(2);
    wb(1, ADR_DATA, 8'h3C);
    for (k = 0; k < 100 && !busy; k++) tick(1);
    tick(2);
    chk(spi_csn, 8'hF7);
    chk({5'h00, clk_oe, mosi_oe, miso_oe}, 8'h06);
    for (k = 0; k < 200 && busy; k++) tick(1);
    chk(spi_csn, CSN_IDLE);
    chk({7'h00, sclk_w}, {7'h00, m[2]});
    wb(0, ADR_DATA, 8'h00);
    chk(d, m[0] ? rev(ptx) : ptx);
    chk(prx, m[0] ? rev(8'h3C) : 8'h3C);
  endtask : t_master
  task automatic t_fault;
    tscsn = 0;
    tick(4);
    chk({5'h00, irq, clk_oe, mosi_oe}, 8'h04);
    tscsn = 1;
    for (i = 0; i < 16; i++) wb(1, ADR_DATA, i[7:0]);
    wb(0, ADR_STAT, 8'h00);
    chk(d, 8'h09);
    wb(1, ADR_DATA, 8'hEE);
    chk({7'h00, ok}, 8'h00);
    wb(1, ADR_STAT, 8'h05);
    chk({7'h00, irq}, 8'h00);
    n = 0;
    got = 8'hFF;
    for (k = 0; k < 3000 && n < 16; k++) begin
      tick(1);
      if (spi_csn[3] && !got[0]) n++;
      got[0] = spi_csn[3];
    end
    chk(n[7:0], 8'h10);
    tick(4);
    wb(0, ADR_STAT, 8'h00);
    chk(d, 8'h06);
  endtask : t_fault
  task automatic t_slave;
    cfg = {1'b0, 3'b000, 2'b11, 3'h0};
    stdby_req = 1;
    tick(3);
    chk({7'h00, stdby}, 8'h01);
    fsn = 0;
    tscsn = 0;
    tick(5);
    chk({4'h0, miso_oe, clk_oe, mosi_oe, wake}, 8'h00);
    fsn = 1;
    for (k = 0; k < 10 && !wake; k++) tick(1);
    chk({7'h00, wake}, 8'h01);
    tick(2);
    chk({7'h00, miso_oe}, 8'h01);
    #13;
    for (i = 7; i >= 0; i--) begin
      tmosi = i[0] ^ i[2];
      #200 tsclk = 1;
      got[i] = miso_w;
      #200 tsclk = 0;
    end
    chk(got, IDLE_FILL);
    tick(6);
    tscsn = 1;
    tick(6);
    wb(0, ADR_DATA, 8'h00);
    chk(d, 8'h5A);
    cfg.wake_en = 0;
    tick(3);
    chk({7'h00, stdby}, 8'h00);
  endtask : t_slave
  initial begin
    {stdby_req, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i, tsclk, tmosi} = '0;
    {tscsn, fsn, rst_b} = 3'b110;
    cfg = {1'b1, 5'h01, 3'h3};
    ptx = 8'h00;
    bad_count = 0;
    num_checks = 0;
    tick(4);
    chk({4'h0, wb_ack, irq, stdby, wake}, 8'h00);
    chk(spi_csn, CSN_IDLE);
    rst_b = 1;
    tick(2);
    for (i = 0; i < 8; i++) t_master(i[2:0]);
    t_fault();
    t_slave();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
